// file: irq_status_and_port_config.sv
/*
  Serial port register slave with the port configuration register, two
  saturating error counters, interrupt enable and write-one-to-clear status.
  Assumes spi_clk, spi_cs_n and the data pins are synchronous to ref_clk and
  spi_clk runs at no more than a quarter of ref_clk.
*/
`timescale 1ns/100ps
`include "irq_port_regs.svh"

module irq_status_and_port_config
  import irq_port_pkg::*;
#(
  parameter int ADDR_WIDTH = 13,
  parameter int DATA_WIDTH = 8
) (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic spi_clk,
  input  wire logic spi_cs_n,
  input  wire logic sdio_in,
  output logic      sdio_out,
  output logic      sdio_oe,
  output logic      sdo_out,
  output logic      sdo_oe,
  output logic      irq_n,
  output logic      soft_reset,
  output logic      low_bit_order_select,
  output logic      long_instruction_mode,
  input  wire logic summing_gain_stage,
  input  wire logic parity_fault_flag,
  input  wire logic self_test_finished_flag,
  input  wire logic param_update_set_event,
  input  wire logic param_update_cleared_event,
  input  wire logic handoff_lock_gained,
  input  wire logic handoff_lock_dropped,
  input  wire logic clip_overflow_flag
);

  typedef struct packed {
    spi_state_e            st;
    logic [3:0]            bit_cnt;
    logic [15:0]           instr;
    logic                  rd;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] rx;
    logic [DATA_WIDTH-1:0] tx;
    logic                  out_bit;
    logic                  sclk_q;
    logic [DATA_WIDTH-1:0] port_config;
    logic [DATA_WIDTH-1:0] interrupt_enable;
    logic [DATA_WIDTH-1:0] interrupt_status_clear;
    logic                  irq_n;
  } regs_s;

  regs_s                 state;
  regs_s                 next_state;
  logic [DATA_WIDTH-1:0] clip_sample_count;
  logic [DATA_WIDTH-1:0] parity_fault_count;
  logic                  clip_count_clear;
  logic                  parity_count_clear;

  // ----------------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------------
  function automatic logic [DATA_WIDTH-1:0] read_reg(
    input logic [ADDR_WIDTH-1:0] a,
    input regs_s                 s,
    input logic [DATA_WIDTH-1:0] clip_cnt,
    input logic [DATA_WIDTH-1:0] par_cnt
  );
    logic [DATA_WIDTH-1:0] d;
    d = `READ_UNMAPPED;
    case (a)
      `ADDR_PORT_CONFIG:  d = s.port_config;
      `ADDR_CLIP_COUNT:   d = clip_cnt;
      `ADDR_PARITY_COUNT: d = par_cnt;
      `ADDR_IRQ_ENABLE:   d = s.interrupt_enable;
      `ADDR_IRQ_STATUS:   d = s.interrupt_status_clear;
      default:            d = `READ_UNMAPPED;
    endcase
    return d;
  endfunction : read_reg

  // Shifts one received bit into a field in the configured bit order.
  function automatic logic [15:0] shift_in(
    input logic [15:0] v,
    input logic        b,
    input logic        lsb_first,
    input logic [3:0]  last
  );
    logic [15:0] r;
    r = {v[14:0], b};
    if (lsb_first) begin
      r = v >> 1;
      r[last] = b;
    end
    return r;
  endfunction : shift_in

  // ----------------------------------------------------------------------
  // Error counters
  // ----------------------------------------------------------------------
  sat_event_counter #(
    .WIDTH (DATA_WIDTH)
  ) u_clip_counter (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .soft_clear (state.port_config[`CFG_SOFT_RESET]),
    .inc        (summing_gain_stage),
    .clear      (clip_count_clear),
    .count      (clip_sample_count)
  );

  sat_event_counter #(
    .WIDTH (DATA_WIDTH)
  ) u_parity_counter (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .soft_clear (state.port_config[`CFG_SOFT_RESET]),
    .inc        (parity_fault_flag),
    .clear      (parity_count_clear),
    .count      (parity_fault_count)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic                  sclk_rise;
    logic                  sclk_fall;
    logic                  lsb_first;
    logic                  wr_strobe;
    logic [DATA_WIDTH-1:0] wr_data;
    logic [DATA_WIDTH-1:0] ev;
    logic [DATA_WIDTH-1:0] set_bits;
    logic [DATA_WIDTH-1:0] clr_bits;
    logic [15:0]           shifted;

    sclk_rise          = spi_clk && !state.sclk_q;
    sclk_fall          = !spi_clk && state.sclk_q;
    lsb_first          = state.port_config[`CFG_LOW_BIT_ORDER];
    wr_strobe          = 1'b0;
    wr_data            = '0;
    shifted            = '0;
    ev                 = '0;
    set_bits           = '0;
    clr_bits           = '0;
    clip_count_clear   = 1'b0;
    parity_count_clear = 1'b0;
    next_state         = state;
    next_state.sclk_q  = spi_clk;

    // Serial sequencer: sample on rising, drive on falling edges.
    case (state.st)
      ST_IDLE: begin
        if (!spi_cs_n) begin
          next_state.st      = ST_INSTR;
          next_state.bit_cnt = '0;
        end
      end
      ST_INSTR: begin
        if (spi_cs_n) begin
          next_state.st = ST_IDLE;
        end else if (sclk_rise) begin
          shifted = shift_in(state.instr, sdio_in, lsb_first, `INSTR_LAST_BIT);
          next_state.instr   = shifted;
          next_state.bit_cnt = state.bit_cnt + 4'h1;
          if (state.bit_cnt == `INSTR_LAST_BIT) begin
            next_state.st      = ST_DATA;
            next_state.bit_cnt = '0;
            next_state.rd      = shifted[`INSTR_READ_BIT];
            next_state.addr    = shifted[ADDR_WIDTH-1:0];
            next_state.tx      = read_reg(shifted[ADDR_WIDTH-1:0], state,
                                          clip_sample_count, parity_fault_count);
          end
        end
      end
      ST_DATA: begin
        if (spi_cs_n) begin
          next_state.st = ST_IDLE;
        end else if (sclk_rise) begin
          shifted = shift_in({8'h00, state.rx}, sdio_in, lsb_first, `DATA_LAST_BIT);
          next_state.rx      = shifted[DATA_WIDTH-1:0];
          next_state.bit_cnt = state.bit_cnt + 4'h1;
          if (state.bit_cnt == `DATA_LAST_BIT) begin
            // Streaming: the address steps up after every byte.
            next_state.bit_cnt = '0;
            next_state.addr    = state.addr + ADDR_WIDTH'(1);
            next_state.tx      = read_reg(state.addr + ADDR_WIDTH'(1), state,
                                          clip_sample_count, parity_fault_count);
            wr_strobe          = !state.rd;
            wr_data            = shifted[DATA_WIDTH-1:0];
          end
        end else if (sclk_fall) begin
          next_state.out_bit = lsb_first ? state.tx[0] : state.tx[DATA_WIDTH-1];
          next_state.tx      = lsb_first ? (state.tx >> 1) : (state.tx << 1);
        end
      end
      ST_SKIP: begin
        if (spi_cs_n) begin
          next_state.st = ST_IDLE;
        end
      end
      default: begin
        next_state.st = ST_IDLE;
      end
    endcase

    // Register writes.
    if (wr_strobe) begin
      case (state.addr)
        `ADDR_PORT_CONFIG: begin
          // Bits 4..0 are stored as written; the host keeps them valid.
          next_state.port_config = wr_data;
        end
        `ADDR_IRQ_ENABLE: begin
          next_state.interrupt_enable = wr_data;
          next_state.interrupt_enable[`IRQ_RESERVED] = 1'b0;
        end
        `ADDR_IRQ_STATUS: begin
          clr_bits = wr_data;
          clip_count_clear   = wr_data[`IRQ_CLIP_OVERFLOW];
          parity_count_clear = wr_data[`IRQ_PARITY_FAULT];
        end
        default: begin
          clr_bits = '0;
        end
      endcase
    end
    clr_bits[`IRQ_LOCK_GAINED] = 1'b0;
    clr_bits[`IRQ_RESERVED]    = 1'b0;

    // Status: an event in the clear cycle still sets its bit.
    ev[`IRQ_PARITY_FAULT]   = parity_fault_flag;
    ev[`IRQ_SELF_TEST_DONE] = self_test_finished_flag;
    ev[`IRQ_PARAM_SET]      = param_update_set_event;
    ev[`IRQ_PARAM_CLEARED]  = param_update_cleared_event;
    ev[`IRQ_LOCK_DROPPED]   = handoff_lock_dropped;
    ev[`IRQ_CLIP_OVERFLOW]  = clip_overflow_flag;
    set_bits = ev & state.interrupt_enable;
    next_state.interrupt_status_clear =
      set_bits | (state.interrupt_status_clear & ~clr_bits);
    // The lock bit is a live level rather than a sticky event.
    next_state.interrupt_status_clear[`IRQ_LOCK_GAINED] =
      handoff_lock_gained && state.interrupt_enable[`IRQ_LOCK_GAINED];
    next_state.interrupt_status_clear[`IRQ_RESERVED] = 1'b0;

    next_state.irq_n = ~|(next_state.interrupt_status_clear &
                          next_state.interrupt_enable);

    // Soft reset: the set bit lives one cycle, then registers and counters return to reset and an open frame is skipped.
    if (state.port_config[`CFG_SOFT_RESET]) begin
      next_state                        = '0;
      next_state.st                     = spi_cs_n ? ST_IDLE : ST_SKIP;
      next_state.sclk_q                 = spi_clk;
      next_state.port_config            = `RST_PORT_CONFIG;
      next_state.interrupt_enable       = `RST_IRQ_ENABLE;
      next_state.interrupt_status_clear = `RST_IRQ_STATUS;
      next_state.irq_n                  = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state                        <= '0;
      state.st                     <= ST_IDLE;
      state.port_config            <= `RST_PORT_CONFIG;
      state.interrupt_enable       <= `RST_IRQ_ENABLE;
      state.interrupt_status_clear <= `RST_IRQ_STATUS;
      state.irq_n                  <= 1'b1;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Read data goes on the data pin in bidirectional mode, else on sdo.
  assign sdio_out = state.out_bit;
  assign sdo_out  = state.out_bit;
  assign sdio_oe  = (state.st == ST_DATA) && state.rd && !spi_cs_n &&
                    state.port_config[`CFG_SDIO_BIDIR];
  assign sdo_oe   = (state.st == ST_DATA) && state.rd && !spi_cs_n &&
                    !state.port_config[`CFG_SDIO_BIDIR];
  assign irq_n    = state.irq_n;
  assign soft_reset            = state.port_config[`CFG_SOFT_RESET];
  assign low_bit_order_select  = state.port_config[`CFG_LOW_BIT_ORDER];
  assign long_instruction_mode = state.port_config[`CFG_LONG_INSTR];

endmodule : irq_status_and_port_config

// file: irq_port_regs.svh
/*
  Register offsets, field positions and reset values of the serial port
  configuration, error counter and interrupt registers.
  Assumes a 13-bit register address taken from a long instruction.
*/
`ifndef IRQ_PORT_REGS_SVH
`define IRQ_PORT_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ADDR_PORT_CONFIG      13'h0000
`define ADDR_CLIP_COUNT       13'h0001
`define ADDR_PARITY_COUNT     13'h0002
`define ADDR_IRQ_ENABLE       13'h0003
`define ADDR_IRQ_STATUS       13'h0004

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CFG_SDIO_BIDIR        7
`define CFG_LOW_BIT_ORDER     6
`define CFG_SOFT_RESET        5
`define CFG_LONG_INSTR        4
`define IRQ_PARITY_FAULT      7
`define IRQ_SELF_TEST_DONE    6
`define IRQ_PARAM_SET         5
`define IRQ_PARAM_CLEARED     4
`define IRQ_LOCK_GAINED       3
`define IRQ_LOCK_DROPPED      2
`define IRQ_CLIP_OVERFLOW     1
`define IRQ_RESERVED          0
`define INSTR_READ_BIT        15
`define INSTR_LAST_BIT        4'hf
`define DATA_LAST_BIT         4'h7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_PORT_CONFIG       8'h18
`define RST_IRQ_ENABLE        8'h00
`define RST_IRQ_STATUS        8'h00
`define RST_COUNT             8'h00
`define READ_UNMAPPED         8'h00

`endif

// file: irq_port_pkg.sv
/*
  Types shared by the serial port register block.
  Assumes the constants of irq_port_regs.svh for offsets and fields.
*/
package irq_port_pkg;

  // ----------------------------------------------------------------------
  // Serial port sequencer states, Gray coded along idle-instr-data
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_INSTR = 2'b01,
    ST_DATA  = 2'b11,
    ST_SKIP  = 2'b10
  } spi_state_e;

endpackage : irq_port_pkg

// file: sat_event_counter.sv
/*
  Saturating event counter with clear, used for the error counters.
  Assumes event and clear strobes synchronous to ref_clk, one cycle each.
*/
`timescale 1ns/100ps
`include "irq_port_regs.svh"

module sat_event_counter #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic             soft_clear,
  input  wire logic             inc,
  input  wire logic             clear,
  output logic      [WIDTH-1:0] count
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
  } cnt_s;

  cnt_s state;
  cnt_s next_state;

  // ----------------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------------
  // An event in the clear cycle is kept, so the count restarts at one.
  always_comb begin
    next_state = state;
    if (soft_clear) begin
      next_state.count = '0;
    end else if (clear) begin
      next_state.count = inc ? WIDTH'(1) : '0;
    end else if (inc && (state.count != {WIDTH{1'b1}})) begin
      next_state.count = state.count + WIDTH'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state.count <= '0;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  assign count = state.count;

endmodule : sat_event_counter

// file: irq_port_chk_asserts.sv
/*
  Concurrent checks on the ports of the status and port configuration block.
  Assumes it is bound to irq_status_and_port_config, with one clock domain.
*/
`timescale 1ns/100ps

module irq_port_chk (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic spi_clk,
  input wire logic spi_cs_n,
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic irq_n,
  input wire logic soft_reset,
  input wire logic low_bit_order_select,
  input wire logic long_instruction_mode,
  input wire logic parity_fault_flag,
  input wire logic self_test_finished_flag,
  input wire logic param_update_set_event,
  input wire logic param_update_cleared_event,
  input wire logic handoff_lock_gained,
  input wire logic handoff_lock_dropped,
  input wire logic clip_overflow_flag
);
  logic ev_any;

  // The interrupt pin may only move for an event, a serial access or a reset.
  assign ev_any = parity_fault_flag | self_test_finished_flag | param_update_set_event |
                  param_update_cleared_event | handoff_lock_gained | handoff_lock_dropped |
                  clip_overflow_flag;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_soft_one_cycle: assert property (
    soft_reset && clk_en |=> !soft_reset && !low_bit_order_select && long_instruction_mode)
    else $error("soft reset pulse or register restore wrong");
  a_soft_cause: assert property (
    $rose(soft_reset) |-> !$past(spi_cs_n)) else $error("soft reset outside a frame");
  a_oe_idle: assert property (
    spi_cs_n |-> !sdio_oe && !sdo_oe) else $error("data pin driven while deselected");
  a_oe_exclusive: assert property (
    !(sdio_oe && sdo_oe)) else $error("both data pins driven");
  a_outs_equal: assert property (
    sdio_out == sdo_out) else $error("data outputs differ");
  a_out_timing: assert property (
    (sdio_oe || sdo_oe) && $changed(sdo_out) |-> !$past(spi_clk))
    else $error("read bit changed while serial clock high");
  a_irq_fall_cause: assert property (
    $fell(irq_n) |-> $past(ev_any) || !$past(spi_cs_n) || !$past(spi_cs_n, 2))
    else $error("interrupt asserted without cause");
  // A dropped lock level is sampled one edge before the pin moves, so look two back.
  a_irq_rise_cause: assert property (
    $rose(irq_n) |-> !$past(spi_cs_n) || !$past(spi_cs_n, 2) || $past(soft_reset) ||
                     $past(handoff_lock_gained, 2))
    else $error("interrupt released without cause");
  a_order_cause: assert property (
    $changed(low_bit_order_select) |-> !$past(spi_cs_n) || $past(soft_reset))
    else $error("bit order changed without write");
  a_long_cause: assert property (
    $changed(long_instruction_mode) |-> !$past(spi_cs_n) || $past(soft_reset))
    else $error("instruction mode changed without write");

  c_irq: cover property ($fell(irq_n));
  c_soft: cover property ($rose(soft_reset));
  c_bidir: cover property (sdio_oe);
  c_sdo: cover property (sdo_oe);
endmodule : irq_port_chk

bind irq_status_and_port_config irq_port_chk i_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .spi_clk(spi_clk),
  .spi_cs_n(spi_cs_n), .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdo_out(sdo_out),
  .sdo_oe(sdo_oe), .irq_n(irq_n), .soft_reset(soft_reset),
  .low_bit_order_select(low_bit_order_select), .long_instruction_mode(long_instruction_mode),
  .parity_fault_flag(parity_fault_flag), .self_test_finished_flag(self_test_finished_flag),
  .param_update_set_event(param_update_set_event),
  .param_update_cleared_event(param_update_cleared_event),
  .handoff_lock_gained(handoff_lock_gained), .handoff_lock_dropped(handoff_lock_dropped),
  .clip_overflow_flag(clip_overflow_flag));

// file: spi_host_model.sv
/*
  Behavioural serial host that configures and polls the register block.
  Assumes ref_clk at 40 MHz; the testbench resolves the shared data line.
*/
`timescale 1ns/100ps

module spi_host_model (
  input  wire logic ref_clk,
  input  wire logic sdio_w,
  input  wire logic sdo_w,
  output logic      spi_clk,
  output logic      spi_cs_n,
  output logic      host_do,
  output logic      host_oe
);
  logic lsb;
  logic bidir;

  initial begin
    lsb      = 1'b0;
    bidir    = 1'b0;
    spi_clk  = 1'b0;
    spi_cs_n = 1'b1;
    host_do  = 1'b0;
    host_oe  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : tick

  // Three ref_clk cycles a phase keeps clear of the two-cycle minimum.
  task automatic shift(input logic [15:0] v, input int n, input logic rel,
                       output logic [15:0] q);
    int k;
    q = 16'h0000;
    for (int i = 0; i < n; i++) begin
      k       = lsb ? i : n - 1 - i;
      host_oe = !rel;
      host_do = v[k];
      tick(3);
      spi_clk = 1'b1;
      q[k]    = bidir ? sdio_w : sdo_w;
      tick(3);
      spi_clk = 1'b0;
    end
  endtask : shift

  task automatic access(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                        output logic [7:0] rdat);
    logic [15:0] q;
    logic [7:0]  d;
    d = wd;
    if (!rd && a == 13'h0000) begin
      d[4:0] = {2'b11, d[5], d[6], d[7]};
    end
    spi_cs_n = 1'b0;
    tick(2);
    shift({rd, 2'b00, a}, 16, 1'b0, q);
    shift({8'h00, d}, 8, rd, q);
    tick(2);
    host_oe  = 1'b0;
    spi_cs_n = 1'b1;
    tick(3);
    rdat = q[7:0];
  endtask : access
endmodule : spi_host_model

// file: irq_status_and_port_config_tb_top.sv
/*
  Self-checking testbench for the status and port configuration block.
  Assumes spi_host_model as serial host and the checker bound in its own file.
*/
`timescale 1ns/100ps
`include "irq_port_regs.svh"

module irq_status_and_port_config_tb_top
  import irq_port_pkg::*;
;
  logic       ref_clk;
  logic       reset_n;
  logic       clk_en;
  logic [7:0] ev;
  logic       spi_clk, spi_cs_n, host_do, host_oe, sdio_w, sdo_w;
  logic       sdio_out, sdio_oe, sdo_out, sdo_oe, irq_n, soft_reset;
  logic       low_bit_order_select, long_instruction_mode;
  int         fails;
  int         n_compared;

  // An undriven line shows the inverse of the last bit, never a stale copy.
  assign sdio_w = sdio_oe ? sdio_out : (host_oe ? host_do : ~sdio_out);
  assign sdo_w  = sdo_oe ? sdo_out : ~sdo_out;

  irq_status_and_port_config i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .sdio_in(sdio_w), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .irq_n(irq_n), .soft_reset(soft_reset),
    .low_bit_order_select(low_bit_order_select), .long_instruction_mode(long_instruction_mode),
    .summing_gain_stage(ev[0]), .parity_fault_flag(ev[7]), .self_test_finished_flag(ev[6]),
    .param_update_set_event(ev[5]), .param_update_cleared_event(ev[4]),
    .handoff_lock_gained(ev[3]), .handoff_lock_dropped(ev[2]), .clip_overflow_flag(ev[1]));

  spi_host_model i_host (
    .ref_clk(ref_clk), .sdio_w(sdio_w), .sdo_w(sdo_w), .spi_clk(spi_clk),
    .spi_cs_n(spi_cs_n), .host_do(host_do), .host_oe(host_oe));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic t(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : t

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] q;
    i_host.access(1'b0, a, d, q);
  endtask : wr

  task automatic rd(input logic [12:0] a, input logic [7:0] exp);
    logic [7:0] q;
    i_host.access(1'b1, a, 8'h00, q);
    chk(q, exp);
  endtask : rd

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (100000) @(posedge ref_clk);
    fails++;
    test_done();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    fails      = 0;
    n_compared = 0;
    reset_n    = 1'b0;
    clk_en     = 1'b1;
    ev         = 8'h00;
    repeat (2) @(posedge ref_clk);
    #2 reset_n = 1'b1;
    t(1);
    chk({6'h00, long_instruction_mode, low_bit_order_select}, 8'h02);
    chk({7'h00, irq_n}, 8'h01);
    rd(`ADDR_PORT_CONFIG, 8'h18);
    rd(`ADDR_IRQ_STATUS, 8'h00);
    rd(13'h0010, 8'h00);
    wr(`ADDR_CLIP_COUNT, 8'h55);
    rd(`ADDR_CLIP_COUNT, 8'h00);
    wr(`ADDR_IRQ_ENABLE, 8'hff);
    rd(`ADDR_IRQ_ENABLE, 8'hfe);
    for (int b = 7; b > 0; b--) begin
      ev[b] = 1'b1;
      t(1);
      if (b != 3) ev[b] = 1'b0;
      t(1);
      chk({7'h00, irq_n}, 8'h00);
      rd(`ADDR_IRQ_STATUS, 8'h01 << b);
      wr(`ADDR_IRQ_STATUS, 8'h00);
      rd(`ADDR_IRQ_STATUS, 8'h01 << b);
      wr(`ADDR_IRQ_STATUS, 8'h01 << b);
      rd(`ADDR_IRQ_STATUS, (b == 3) ? 8'h08 : 8'h00);
      ev = 8'h00;
      t(2);
      chk({7'h00, irq_n}, 8'h01);
    end
    wr(`ADDR_IRQ_ENABLE, 8'h00);
    ev[7] = 1'b1;
    t(3);
    ev[7] = 1'b0;
    t(2);
    chk({7'h00, irq_n}, 8'h01);
    rd(`ADDR_IRQ_STATUS, 8'h00);
    rd(`ADDR_PARITY_COUNT, 8'h03);
    ev[0] = 1'b1;
    t(260);
    ev[0] = 1'b0;
    rd(`ADDR_CLIP_COUNT, 8'hff);
    wr(`ADDR_IRQ_STATUS, 8'h02);
    rd(`ADDR_CLIP_COUNT, 8'h00);
    rd(`ADDR_PARITY_COUNT, 8'h03);
    clk_en = 1'b0;
    ev[0]  = 1'b1;
    t(4);
    ev[0]  = 1'b0;
    clk_en = 1'b1;
    rd(`ADDR_CLIP_COUNT, 8'h00);
    wr(`ADDR_IRQ_STATUS, 8'h80);
    rd(`ADDR_PARITY_COUNT, 8'h00);
    wr(`ADDR_PORT_CONFIG, 8'h40);
    chk({7'h00, low_bit_order_select}, 8'h01);
    i_host.lsb = 1'b1;
    rd(`ADDR_PORT_CONFIG, 8'h5a);
    wr(`ADDR_IRQ_ENABLE, 8'h86);
    wr(`ADDR_PORT_CONFIG, 8'hc0);
    i_host.bidir = 1'b1;
    rd(`ADDR_IRQ_ENABLE, 8'h86);
    ev[0] = 1'b1;
    t(2);
    ev[0] = 1'b0;
    rd(`ADDR_CLIP_COUNT, 8'h02);
    wr(`ADDR_PORT_CONFIG, 8'he0);
    i_host.lsb   = 1'b0;
    i_host.bidir = 1'b0;
    rd(`ADDR_PORT_CONFIG, 8'h18);
    rd(`ADDR_IRQ_ENABLE, 8'h00);
    rd(`ADDR_CLIP_COUNT, 8'h00);
    test_done();
  end
endmodule : irq_status_and_port_config_tb_top
